// File: fac_pkg.sv
// shared constants and types of the file access command unit
package fac_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_TARGET_SEL  = 8'h00;
	localparam logic [7:0] ADDR_ACTION_SEL  = 8'h04;
	localparam logic [7:0] ADDR_OPEN_KIND   = 8'h08;
	localparam logic [7:0] ADDR_START_POS   = 8'h0C;
	localparam logic [7:0] ADDR_BYTE_COUNT  = 8'h10;
	localparam logic [7:0] ADDR_TRIGGER     = 8'h14;
	localparam logic [7:0] ADDR_OUTCOME     = 8'h18;
	localparam logic [7:0] ADDR_TALLY       = 8'h1C;
	localparam logic [7:0] ADDR_TARGET_SIZE = 8'h20;
	localparam logic [7:0] ADDR_REMOTE_FLAG = 8'h24;
	localparam logic [7:0] ADDR_FRAME_CAP   = 8'h28;
	localparam logic [7:0] ADDR_FRAME_STORE = 8'h2C;
	localparam logic [7:0] ADDR_RESTART     = 8'h30;
	localparam logic [7:0] ADDR_CORR_SEL    = 8'h34;
	localparam logic [7:0] ADDR_WINDOW      = 8'h40;
	// field positions
	localparam int OUTCOME_BUSY_BIT = 8;
	localparam int CORR_USER_LSB    = 8;
	localparam int CORR_PEND_BIT    = 16;
	// reset values
	localparam logic [4:0] TARGET_SEL_RESET = 5'h00;
	localparam logic [2:0] ACTION_SEL_RESET = 3'h0;
	// storage geometry: every target owns one region of the scratch size
	localparam int REGION_BYTES = 4096;
	localparam int REGION_AW    = 12;
	localparam int SIZE_W       = 13;
	localparam int NUM_TARGETS  = 20;
	localparam int TARGET_W     = 5;
	localparam int STORE_AW     = TARGET_W + REGION_AW;
	// target codes
	localparam logic [4:0] TGT_CODE_IMAGE   = 5'h00;
	localparam logic [4:0] TGT_FACT_DEFECT  = 5'h01;
	localparam logic [4:0] TGT_USER_DEFECT  = 5'h02;
	localparam logic [4:0] TGT_FACT_CORR0   = 5'h03;
	localparam logic [4:0] TGT_USER_CORR0   = 5'h0B;
	localparam logic [4:0] TGT_LENS_SHADE0  = 5'h0F;
	localparam logic [4:0] TGT_SAVED_FRAME  = 5'h11;
	localparam logic [4:0] TGT_LICENSES     = 5'h12;
	localparam logic [4:0] TGT_SCRATCH      = 5'h13;
	localparam logic [4:0] FACT_QUICK_STEP  = 5'h04;
	// action codes
	localparam logic [2:0] ACT_OPEN   = 3'h0;
	localparam logic [2:0] ACT_CLOSE  = 3'h1;
	localparam logic [2:0] ACT_READ   = 3'h2;
	localparam logic [2:0] ACT_WRITE  = 3'h3;
	localparam logic [2:0] ACT_DELETE = 3'h4;
	// open access kinds
	localparam logic KIND_READ  = 1'b0;
	localparam logic KIND_WRITE = 1'b1;
	// outcome codes
	localparam logic [1:0] OUT_SUCCESS = 2'h0;
	localparam logic [1:0] OUT_FAILURE = 2'h1;
	localparam logic [1:0] OUT_BUSY    = 2'h2;
	localparam logic [1:0] OUT_ABSENT  = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RD_ADDR,
		ST_RD_DATA,
		ST_WR,
		ST_FR_ADDR,
		ST_FR_WAIT,
		ST_FR_DATA
	} fac_state_type;
endpackage

// File: fac_mem_if.sv
// byte port between the command unit and its flash store
`timescale 1ns/1ps
interface fac_mem_if;
	import fac_pkg::*;
	logic [STORE_AW-1:0] addr;
	logic [7:0]          wdata;
	logic                we;
	logic [7:0]          rdata;
	modport host (output addr, output wdata, output we, input rdata);
	modport mem  (input addr, input wdata, input we, output rdata);
endinterface

// File: fac_store.sv
// byte-wide file store, one region per target, read data one cycle later
`timescale 1ns/1ps
module fac_store
	import fac_pkg::*;
(
	// clock
	input wire logic core_clk,
	// store port
	fac_mem_if.mem   port
);
	logic [7:0] mem_array [0:(1 << STORE_AW)-1];
	logic [7:0] rdata_reg;

	// no reset on the array: flash content survives a reset
	always_ff @(posedge core_clk) begin
		if (port.we) begin
			mem_array[port.addr] <= port.wdata;
		end
		rdata_reg <= mem_array[port.addr];
	end

	assign port.rdata = rdata_reg;
endmodule

// File: fac_file_access.sv
// file access command unit: target, action, transfer window and outcome
`timescale 1ns/1ps
// Function
// - host picks stored file by target select
// - code image waits for unit restart
// - eight factory sets by quick scan, gain
// - four user sets chosen by gain
// - five actions, run only on trigger
// - trigger runs selected action on target
// - open kind read-only or write-only
// - transfer window exchanges data with storage
// - start position maps window into file
// - byte count sets mapped length
// - one outcome code after each action
// - bytes moved reported after read, write
// - size of selected target is readable
// - frame store command copies latest image
// - free scratch area for the user
// - read-only remote transfer capability flag
// - stored frame capacity readable
// - scratch area 4 kB, never overwritten internally
module fac_file_access
	import fac_pkg::*;
#(
	parameter int                  WIN_BYTES    = 64,
	parameter logic [NUM_TARGETS-1:0] PRESENT_MASK = 20'hFFFFF,
	parameter logic                REMOTE_CAPABLE = 1'b0
)(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// imaging state
	input  wire logic        quick_scan_setting,
	input  wire logic [1:0]  gain_step,
	// latest frame source, data one cycle after address
	input  wire logic [SIZE_W-1:0] frame_byte_count,
	input  wire logic [7:0]  frame_rd_data,
	output logic [REGION_AW-1:0] frame_rd_addr,
	output logic             frame_rd_en,
	// correction set selection and restart
	output logic [4:0]       factory_gain_correction_set,
	output logic [4:0]       user_gain_correction_set,
	output logic             unit_restart_cmd,
	output logic             code_image_pending
);
	localparam int WIN_AW = $clog2(WIN_BYTES);
	if (WIN_BYTES < 4 || WIN_BYTES > 64 || (WIN_BYTES % 4) != 0) begin : g_win_check
		$error("WIN_BYTES must be a multiple of 4 between 4 and 64");
	end
	fac_mem_if mem_bus ();
	fac_store u_store (
		.core_clk (core_clk),
		.port     (mem_bus.mem)
	);
	fac_state_type            state_reg;
	fac_state_type            state_next;
	logic [4:0]               target_sel_reg;
	logic [2:0]               action_sel_reg;
	logic                     open_kind_reg;
	logic [REGION_AW-1:0]     start_pos_reg;
	logic [6:0]               byte_count_reg;
	logic [1:0]               outcome_reg;
	logic [SIZE_W-1:0]        tally_reg;
	logic                     open_valid_reg;
	logic [4:0]               open_target_reg;
	logic                     open_mode_reg;
	logic [4:0]               job_target_reg;
	logic [REGION_AW-1:0]     job_start_reg;
	logic [SIZE_W-1:0]        job_len_reg;
	logic [SIZE_W-1:0]        job_idx_reg;
	logic [SIZE_W-1:0]        size_reg [0:NUM_TARGETS-1];
	logic [7:0]               window_reg [0:WIN_BYTES-1];
	logic [31:0]              rdata_reg;
	logic [4:0]               fact_set_reg;
	logic [4:0]               user_set_reg;
	logic                     restart_reg;
	logic                     pending_reg;
	logic [REGION_AW-1:0]     frame_addr_reg;
	logic                     frame_en_reg;
	// register decode
	wire        hit_window   = reg_addr >= ADDR_WINDOW
	                           && reg_addr < ADDR_WINDOW + 8'(WIN_BYTES);
	wire [7:0]  win_byte     = reg_addr - ADDR_WINDOW;
	wire [WIN_AW-1:0] win_base = WIN_AW'({win_byte[7:2], 2'b00});
	wire        wr_trigger   = reg_wr && reg_addr == ADDR_TRIGGER && reg_wdata[0];
	wire        wr_frame     = reg_wr && reg_addr == ADDR_FRAME_STORE && reg_wdata[0];
	wire        wr_restart   = reg_wr && reg_addr == ADDR_RESTART && reg_wdata[0];
	wire        idle         = state_reg == ST_IDLE;
	// target properties
	wire        tgt_valid    = target_sel_reg < 5'(NUM_TARGETS);
	wire        tgt_present  = tgt_valid && PRESENT_MASK[target_sel_reg];
	wire        tgt_ro       = target_sel_reg == TGT_FACT_DEFECT
	                           || target_sel_reg == TGT_LICENSES
	                           || (target_sel_reg >= TGT_FACT_CORR0
	                               && target_sel_reg < TGT_USER_CORR0);
	wire [SIZE_W-1:0] tgt_size = tgt_valid ? size_reg[target_sel_reg] : '0;
	wire        open_here    = open_valid_reg && open_target_reg == target_sel_reg;
	wire        open_other   = open_valid_reg && open_target_reg != target_sel_reg;
	// mapped length of the window inside the file
	wire [SIZE_W-1:0] start_ext = SIZE_W'(start_pos_reg);
	wire [SIZE_W-1:0] cnt_ext   = SIZE_W'(byte_count_reg);
	wire [SIZE_W-1:0] cnt_lim   = cnt_ext > SIZE_W'(WIN_BYTES) ? SIZE_W'(WIN_BYTES)
	                                                           : cnt_ext;
	wire [SIZE_W-1:0] avail_rd  = start_ext < tgt_size ? tgt_size - start_ext : '0;
	wire [SIZE_W-1:0] avail_wr  = SIZE_W'(REGION_BYTES) - start_ext;
	wire [SIZE_W-1:0] len_rd    = cnt_lim < avail_rd ? cnt_lim : avail_rd;
	wire [SIZE_W-1:0] len_wr    = cnt_lim < avail_wr ? cnt_lim : avail_wr;
	wire [SIZE_W-1:0] frame_cap = SIZE_W'(REGION_BYTES);
	wire [SIZE_W-1:0] frame_len = frame_byte_count < frame_cap ? frame_byte_count
	                                                           : frame_cap;
	// action decision on a trigger
	wire        go_read   = action_sel_reg == ACT_READ && open_here
	                        && open_mode_reg == KIND_READ;
	wire        go_write  = action_sel_reg == ACT_WRITE && open_here
	                        && open_mode_reg == KIND_WRITE && !tgt_ro;
	wire        take_trig = wr_trigger && idle;
	wire        last_byte = job_idx_reg + 1'b1 == job_len_reg;
	wire [SIZE_W-1:0] wr_end = SIZE_W'(job_start_reg) + job_len_reg;
	// outcome of every action, decided in the trigger cycle
	logic [1:0] trig_outcome;
	always_comb begin
		trig_outcome = OUT_FAILURE;
		if (!tgt_present) begin
			trig_outcome = OUT_ABSENT;
		end else begin
			case (action_sel_reg)
				ACT_OPEN:   trig_outcome = open_other ? OUT_BUSY
					: (open_kind_reg == KIND_WRITE && tgt_ro) ? OUT_FAILURE
					: OUT_SUCCESS;
				ACT_CLOSE:  trig_outcome = open_here ? OUT_SUCCESS : OUT_FAILURE;
				ACT_READ:   trig_outcome = go_read ? OUT_SUCCESS : OUT_FAILURE;
				ACT_WRITE:  trig_outcome = go_write ? OUT_SUCCESS : OUT_FAILURE;
				ACT_DELETE: trig_outcome = tgt_ro ? OUT_FAILURE
					: open_here ? OUT_BUSY : OUT_SUCCESS;
				default:    trig_outcome = OUT_FAILURE;
			endcase
		end
	end
	// sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (take_trig && tgt_present && go_read && len_rd != '0) begin
					state_next = ST_RD_ADDR;
				end else if (take_trig && tgt_present && go_write && len_wr != '0) begin
					state_next = ST_WR;
				end else if (wr_frame && !wr_trigger && frame_len != '0) begin
					state_next = ST_FR_ADDR;
				end
			end
			ST_RD_ADDR: state_next = ST_RD_DATA;
			ST_RD_DATA: state_next = last_byte ? ST_IDLE : ST_RD_ADDR;
			ST_WR:      state_next = last_byte ? ST_IDLE : ST_WR;
			ST_FR_ADDR: state_next = ST_FR_WAIT;
			ST_FR_WAIT: state_next = ST_FR_DATA;
			ST_FR_DATA: state_next = last_byte ? ST_IDLE : ST_FR_ADDR;
			default:    state_next = ST_IDLE;
		endcase
	end

	// store port: read address shown one cycle before its data is taken
	wire [REGION_AW-1:0] job_pos = job_start_reg + REGION_AW'(job_idx_reg);
	wire [WIN_AW-1:0]    job_win = WIN_AW'(job_idx_reg);
	assign mem_bus.addr  = state_reg == ST_FR_DATA ? {TGT_SAVED_FRAME, job_pos}
	                                              : {job_target_reg, job_pos};
	assign mem_bus.we    = state_reg == ST_WR || state_reg == ST_FR_DATA;
	assign mem_bus.wdata = state_reg == ST_FR_DATA ? frame_rd_data : window_reg[job_win];
	// host-set selections
	always_ff @(posedge core_clk) begin
		if (reset) begin
			target_sel_reg <= TARGET_SEL_RESET;
			action_sel_reg <= ACTION_SEL_RESET;
			open_kind_reg  <= KIND_READ;
			start_pos_reg  <= '0;
			byte_count_reg <= '0;
		end else if (reg_wr) begin
			case (reg_addr)
				ADDR_TARGET_SEL: target_sel_reg <= reg_wdata[4:0];
				ADDR_ACTION_SEL: action_sel_reg <= reg_wdata[2:0];
				ADDR_OPEN_KIND:  open_kind_reg  <= reg_wdata[0];
				ADDR_START_POS:  start_pos_reg  <= reg_wdata[REGION_AW-1:0];
				ADDR_BYTE_COUNT: byte_count_reg <= reg_wdata[6:0];
				default: ;
			endcase
		end
	end
	// action execution, open state and results
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg       <= ST_IDLE;
			outcome_reg     <= OUT_SUCCESS;
			tally_reg       <= '0;
			open_valid_reg  <= 1'b0;
			open_target_reg <= '0;
			open_mode_reg   <= KIND_READ;
			job_target_reg  <= '0;
			job_start_reg   <= '0;
			job_len_reg     <= '0;
			job_idx_reg     <= '0;
		end else begin
			state_reg <= state_next;
			if (take_trig) begin
				outcome_reg <= trig_outcome;
				tally_reg   <= '0;
				if (tgt_present && action_sel_reg == ACT_OPEN
				    && trig_outcome == OUT_SUCCESS) begin
					open_valid_reg  <= 1'b1;
					open_target_reg <= target_sel_reg;
					open_mode_reg   <= open_kind_reg;
				end
				if (tgt_present && action_sel_reg == ACT_CLOSE && open_here) begin
					open_valid_reg <= 1'b0;
				end
				if (tgt_present && (go_read || go_write)) begin
					tally_reg      <= go_read ? len_rd : len_wr;
					job_target_reg <= target_sel_reg;
					job_start_reg  <= start_pos_reg;
					job_len_reg    <= go_read ? len_rd : len_wr;
					job_idx_reg    <= '0;
				end
			end else if (idle && wr_frame) begin
				job_start_reg <= '0;
				job_len_reg   <= frame_len;
				job_idx_reg   <= '0;
			end
			if (state_reg == ST_RD_DATA || state_reg == ST_WR || state_reg == ST_FR_DATA) begin
				job_idx_reg <= job_idx_reg + 1'b1;
			end
		end
	end

	// file sizes: read-only factory files come up full, others empty
	genvar t;
	generate
		for (t = 0; t < NUM_TARGETS; t++) begin : g_size
			localparam logic [4:0] TID = 5'(t);
			localparam logic RO = TID == TGT_FACT_DEFECT || TID == TGT_LICENSES
			                      || (TID >= TGT_FACT_CORR0 && TID < TGT_USER_CORR0);
			wire del_hit = take_trig && target_sel_reg == TID && tgt_present
			               && action_sel_reg == ACT_DELETE && trig_outcome == OUT_SUCCESS;
			wire wr_grow = state_reg == ST_WR && last_byte && job_target_reg == TID
			               && wr_end > size_reg[t];
			// only the frame copy may write on its own; it never aims at the scratch area
			wire fr_done = state_reg == ST_FR_DATA && last_byte
			               && TID == TGT_SAVED_FRAME;
			always_ff @(posedge core_clk) begin
				if (reset) begin
					size_reg[t] <= RO ? SIZE_W'(REGION_BYTES) : '0;
				end else if (del_hit) begin
					size_reg[t] <= '0;
				end else if (wr_grow) begin
					size_reg[t] <= wr_end;
				end else if (fr_done) begin
					size_reg[t] <= job_len_reg;
				end
			end
		end
	endgenerate
	// transfer window: software words on one side, store bytes on the other
	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int i = 0; i < WIN_BYTES; i++) begin
				window_reg[i] <= 8'h00;
			end
		end else if (state_reg == ST_RD_DATA) begin
			window_reg[job_win] <= mem_bus.rdata;
		end else if (reg_wr && hit_window) begin
			for (int b = 0; b < 4; b++) begin
				window_reg[win_base + WIN_AW'(b)] <= reg_wdata[8*b +: 8];
			end
		end
	end
	// latest frame fetch
	always_ff @(posedge core_clk) begin
		if (reset) begin
			frame_addr_reg <= '0;
			frame_en_reg   <= 1'b0;
		end else begin
			frame_en_reg <= state_reg == ST_FR_ADDR;
			if (state_reg == ST_FR_ADDR) begin
				frame_addr_reg <= REGION_AW'(job_idx_reg);
			end
		end
	end
	// correction set choice and restart handling
	always_ff @(posedge core_clk) begin
		if (reset) begin
			fact_set_reg <= TGT_FACT_CORR0;
			user_set_reg <= TGT_USER_CORR0;
			restart_reg  <= 1'b0;
			pending_reg  <= 1'b0;
		end else begin
			fact_set_reg <= TGT_FACT_CORR0 + (quick_scan_setting ? FACT_QUICK_STEP : 5'h00)
			                + 5'(gain_step);
			user_set_reg <= TGT_USER_CORR0 + 5'(gain_step);
			restart_reg  <= wr_restart;
			// a finishing upload in the restart cycle stays pending for the next one
			if (state_reg == ST_WR && last_byte && job_target_reg == TGT_CODE_IMAGE) begin
				pending_reg <= 1'b1;
			end else if (wr_restart) begin
				pending_reg <= 1'b0;
			end
		end
	end

	// read mux, answered in the next cycle only
	logic [31:0] read_mux;
	wire  [WIN_AW-1:0] rb = win_base;
	always_comb begin
		read_mux = 32'h0000_0000;
		if (hit_window) begin
			read_mux = {window_reg[rb + WIN_AW'(3)], window_reg[rb + WIN_AW'(2)],
			            window_reg[rb + WIN_AW'(1)], window_reg[rb]};
		end else begin
			case (reg_addr)
				ADDR_TARGET_SEL:  read_mux = 32'(target_sel_reg);
				ADDR_ACTION_SEL:  read_mux = 32'(action_sel_reg);
				ADDR_OPEN_KIND:   read_mux = 32'(open_kind_reg);
				ADDR_START_POS:   read_mux = 32'(start_pos_reg);
				ADDR_BYTE_COUNT:  read_mux = 32'(byte_count_reg);
				ADDR_OUTCOME: begin
					read_mux = 32'(outcome_reg);
					read_mux[OUTCOME_BUSY_BIT] = !idle;
				end
				ADDR_TALLY:       read_mux = 32'(tally_reg);
				ADDR_TARGET_SIZE: read_mux = 32'(tgt_size);
				ADDR_REMOTE_FLAG: read_mux = 32'(REMOTE_CAPABLE);
				ADDR_FRAME_CAP:   read_mux = 32'(frame_cap);
				ADDR_CORR_SEL: begin
					read_mux[4:0] = fact_set_reg;
					read_mux[CORR_USER_LSB +: 5] = user_set_reg;
					read_mux[CORR_PEND_BIT] = pending_reg;
				end
				default:          read_mux = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			rdata_reg <= 32'h0000_0000;
		end else begin
			rdata_reg <= reg_rd ? read_mux : 32'h0000_0000;
		end
	end

	// the scratch target is an ordinary writable region of the store
	assign reg_rdata                   = rdata_reg;
	assign frame_rd_addr               = frame_addr_reg;
	assign frame_rd_en                 = frame_en_reg;
	assign factory_gain_correction_set = fact_set_reg;
	assign user_gain_correction_set    = user_set_reg;
	assign unit_restart_cmd            = restart_reg;
	assign code_image_pending          = pending_reg;
endmodule

// File: fac_frame_src.sv
// latest frame source model answering byte reads one cycle later
`timescale 1ns/1ps
module fac_frame_src
	import fac_pkg::*;
(
	// clock
	input wire logic                 core_clk,
	// frame read port
	input wire logic                 frame_rd_en,
	input wire logic [REGION_AW-1:0] frame_rd_addr,
	output logic     [7:0]           frame_rd_data
);
	// outside the answer cycle the byte flips every cycle, so a sample taken one cycle late never matches
	always_ff @(posedge core_clk) begin
		if (frame_rd_en) begin
			frame_rd_data <= frame_rd_addr[7:0] ^ 8'h5A;
		end else begin
			frame_rd_data <= ~frame_rd_data;
		end
	end
endmodule

// File: fac_file_access_assertions.sv
// port checks of the file access command unit
`timescale 1ns/1ps
module fac_chk
	import fac_pkg::*;
#(
	parameter logic REMOTE_CAPABLE = 1'b0
)(
	// clock and reset
	input wire logic                 core_clk,
	input wire logic                 reset,
	// register port
	input wire logic [7:0]           reg_addr,
	input wire logic [31:0]          reg_wdata,
	input wire logic                 reg_wr,
	input wire logic                 reg_rd,
	input wire logic [31:0]          reg_rdata,
	// imaging and frame side
	input wire logic                 quick_scan_setting,
	input wire logic [1:0]           gain_step,
	input wire logic [REGION_AW-1:0] frame_rd_addr,
	input wire logic                 frame_rd_en,
	// correction and restart
	input wire logic [4:0]           factory_gain_correction_set,
	input wire logic [4:0]           user_gain_correction_set,
	input wire logic                 unit_restart_cmd
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	wire logic rst_wr = reg_wr && reg_addr == ADDR_RESTART && reg_wdata[0];
	wire logic rd_corr = reg_rd && reg_addr == ADDR_CORR_SEL;

	property p_rdata_idle;
		!$past(reg_rd) |-> reg_rdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
	property p_restart_pulse;
		rst_wr |=> unit_restart_cmd ##1 unit_restart_cmd == $past(rst_wr);
	endproperty
	a_restart_pulse: assert property (p_restart_pulse) else $error("no restart pulse");
	property p_restart_cause;
		unit_restart_cmd |-> $past(rst_wr);
	endproperty
	a_restart_cause: assert property (p_restart_cause) else $error("stray restart");
	property p_fact_set;
		!$past(reset) |-> factory_gain_correction_set ==
			TGT_FACT_CORR0 + {$past(quick_scan_setting), $past(gain_step)};
	endproperty
	a_fact_set: assert property (p_fact_set) else $error("factory set wrong");
	property p_user_set;
		!$past(reset) |-> user_gain_correction_set == TGT_USER_CORR0 + $past(gain_step);
	endproperty
	a_user_set: assert property (p_user_set) else $error("user set wrong");
	property p_corr_read;
		rd_corr |=> reg_rdata[12:0] ==
			{$past(user_gain_correction_set), 3'h0, $past(factory_gain_correction_set)};
	endproperty
	a_corr_read: assert property (p_corr_read) else $error("set readback wrong");
	property p_cap_read;
		reg_rd && reg_addr == ADDR_FRAME_CAP |=> reg_rdata == 32'h0000_1000;
	endproperty
	a_cap_read: assert property (p_cap_read) else $error("capacity wrong");
	property p_remote_read;
		reg_rd && reg_addr == ADDR_REMOTE_FLAG |=> reg_rdata == {31'h0, REMOTE_CAPABLE};
	endproperty
	a_remote_read: assert property (p_remote_read) else $error("remote flag wrong");
	property p_frame_gap;
		frame_rd_en |=> !frame_rd_en [*2];
	endproperty
	a_frame_gap: assert property (p_frame_gap) else $error("frame reads too close");
	property p_frame_step;
		frame_rd_en && $past(frame_rd_en, 3) |->
			frame_rd_addr == $past(frame_rd_addr, 3) + 12'h001;
	endproperty
	a_frame_step: assert property (p_frame_step) else $error("frame address skip");

	c_restart: cover property (unit_restart_cmd);
	c_frame: cover property (frame_rd_en && $past(frame_rd_en, 3));
	c_quick_top: cover property (factory_gain_correction_set == 5'h0A);
endmodule

bind fac_file_access fac_chk #(.REMOTE_CAPABLE(REMOTE_CAPABLE)) i_fac_chk (
	.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.quick_scan_setting(quick_scan_setting), .gain_step(gain_step),
	.frame_rd_addr(frame_rd_addr), .frame_rd_en(frame_rd_en),
	.factory_gain_correction_set(factory_gain_correction_set),
	.user_gain_correction_set(user_gain_correction_set),
	.unit_restart_cmd(unit_restart_cmd));

// File: tb.sv
// self-checking bench of the file access command unit
`timescale 1ns/1ps
`define CHK(nm, e, s) begin tests_run++; if ((e) !== (s)) begin n_errors++; \
	$display("Error %s exp %0h got %0h", nm, e, s); end end
module tb;
	import fac_pkg::*;
	logic              core_clk = 1'b0;
	logic              reset = 1'b1;
	logic [7:0]        reg_addr = 8'h00;
	logic [31:0]       reg_wdata = 32'h0;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic [31:0]       reg_rdata;
	logic              quick_scan_setting = 1'b0;
	logic [1:0]        gain_step = 2'h0;
	logic [SIZE_W-1:0] frame_byte_count = 13'h0000;
	logic [7:0]        frame_rd_data;
	logic [REGION_AW-1:0] frame_rd_addr;
	logic              frame_rd_en;
	logic [4:0]        fact_set;
	logic [4:0]        user_set;
	logic              unit_restart_cmd;
	logic              code_image_pending;
	int                n_errors = 0;
	int                tests_run = 0;
	int                cyc = 0;
	logic [31:0]       d;

	fac_file_access i_fac_file_access (.core_clk(core_clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .quick_scan_setting(quick_scan_setting),
		.gain_step(gain_step), .frame_byte_count(frame_byte_count),
		.frame_rd_data(frame_rd_data), .frame_rd_addr(frame_rd_addr),
		.frame_rd_en(frame_rd_en), .factory_gain_correction_set(fact_set),
		.user_gain_correction_set(user_set), .unit_restart_cmd(unit_restart_cmd),
		.code_image_pending(code_image_pending));
	fac_frame_src i_fac_frame_src (.core_clk(core_clk), .frame_rd_en(frame_rd_en),
		.frame_rd_addr(frame_rd_addr), .frame_rd_data(frame_rd_data));

	initial forever #4 core_clk = ~core_clk;

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic act(input logic [2:0] a, input logic [1:0] e);
		logic [31:0] r;
		wr(ADDR_ACTION_SEL, {29'h0, a});
		wr(ADDR_TRIGGER, 32'h1);
		rd(ADDR_OUTCOME, r);
		`CHK("outcome", e, r[1:0])
	endtask
	task automatic idle();
		logic [31:0] r;
		int n = 0;
		do begin rd(ADDR_OUTCOME, r); n++; end while (r[OUTCOME_BUSY_BIT] !== 1'b0 && n < 200);
		`CHK("busy", 1'b0, r[OUTCOME_BUSY_BIT])
	endtask

	task automatic t_reset();
		rd(ADDR_CORR_SEL, d); `CHK("sets", 32'h0000_0B03, d)
		rd(ADDR_FRAME_CAP, d); `CHK("cap", 32'h0000_1000, d)
		rd(ADDR_REMOTE_FLAG, d); `CHK("remote", 32'h0, d)
		rd(8'hFC, d); `CHK("unmapped", 32'h0, d)
		rd(ADDR_OUTCOME, d); `CHK("outcome0", 32'h0, d)
		wr(ADDR_TARGET_SEL, 32'h01);
		rd(ADDR_TARGET_SIZE, d); `CHK("size1", 32'd4096, d)
		wr(ADDR_TARGET_SEL, 32'h14);
		act(ACT_OPEN, OUT_ABSENT);
		wr(ADDR_TARGET_SEL, 32'h13);
		rd(ADDR_TARGET_SIZE, d); `CHK("size19", 32'h0, d)
	endtask
	task automatic t_corr();
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk);
			quick_scan_setting <= i[2];
			gain_step <= i[1:0];
			repeat (2) @(posedge core_clk);
			#1 `CHK("fact", TGT_FACT_CORR0 + 5'(i), fact_set)
			`CHK("user", TGT_USER_CORR0 + 5'(i[1:0]), user_set)
			rd(ADDR_CORR_SEL, d);
		end
		@(posedge core_clk);
		quick_scan_setting <= 1'b0;
		gain_step <= 2'h0;
	endtask
	// refusals first, then a write and a clipped read back through the window
	task automatic t_file();
		act(ACT_CLOSE, OUT_FAILURE);
		wr(ADDR_OPEN_KIND, {31'h0, KIND_WRITE});
		wr(ADDR_TARGET_SEL, 32'h01);
		act(ACT_OPEN, OUT_FAILURE);
		wr(ADDR_TARGET_SEL, 32'h13);
		act(ACT_OPEN, OUT_SUCCESS);
		wr(ADDR_TARGET_SEL, 32'h02);
		act(ACT_OPEN, OUT_BUSY);
		wr(ADDR_TARGET_SEL, 32'h13);
		act(ACT_READ, OUT_FAILURE);
		wr(ADDR_WINDOW, 32'h4433_2211);
		wr(ADDR_WINDOW + 8'h04, 32'h0000_0055);
		wr(ADDR_START_POS, 32'd8);
		wr(ADDR_BYTE_COUNT, 32'd5);
		act(ACT_WRITE, OUT_SUCCESS);
		idle();
		rd(ADDR_TALLY, d); `CHK("wr tally", 32'd5, d)
		rd(ADDR_TARGET_SIZE, d); `CHK("size", 32'd13, d)
		act(ACT_CLOSE, OUT_SUCCESS);
		wr(ADDR_OPEN_KIND, {31'h0, KIND_READ});
		act(ACT_OPEN, OUT_SUCCESS);
		wr(ADDR_WINDOW, 32'h0);
		wr(ADDR_WINDOW + 8'h04, 32'h0);
		wr(ADDR_START_POS, 32'd9);
		wr(ADDR_BYTE_COUNT, 32'd8);
		act(ACT_READ, OUT_SUCCESS);
		idle();
		rd(ADDR_TALLY, d); `CHK("rd tally", 32'd4, d)
		rd(ADDR_WINDOW, d); `CHK("win0", 32'h5544_3322, d)
		rd(ADDR_WINDOW + 8'h04, d); `CHK("win1", 32'h0, d)
		act(ACT_CLOSE, OUT_SUCCESS);
	endtask
	task automatic t_frame();
		@(posedge core_clk);
		frame_byte_count <= 13'h0003;
		wr(ADDR_FRAME_STORE, 32'h1);
		repeat (12) @(posedge core_clk);
		idle();
		wr(ADDR_TARGET_SEL, {27'h0, TGT_SAVED_FRAME});
		rd(ADDR_TARGET_SIZE, d); `CHK("frame size", 32'd3, d)
		act(ACT_OPEN, OUT_SUCCESS);
		wr(ADDR_START_POS, 32'd0);
		wr(ADDR_BYTE_COUNT, 32'd3);
		act(ACT_READ, OUT_SUCCESS);
		idle();
		rd(ADDR_WINDOW, d); `CHK("frame bytes", 24'h585B5A, d[23:0])
		act(ACT_CLOSE, OUT_SUCCESS);
		wr(ADDR_TARGET_SEL, {27'h0, TGT_SCRATCH});
		rd(ADDR_TARGET_SIZE, d); `CHK("scratch kept", 32'd13, d)
		act(ACT_DELETE, OUT_SUCCESS);
		rd(ADDR_TARGET_SIZE, d); `CHK("deleted", 32'h0, d)
	endtask
	task automatic t_restart();
		wr(ADDR_TARGET_SEL, {27'h0, TGT_CODE_IMAGE});
		wr(ADDR_OPEN_KIND, {31'h0, KIND_WRITE});
		act(ACT_OPEN, OUT_SUCCESS);
		wr(ADDR_BYTE_COUNT, 32'd1);
		act(ACT_WRITE, OUT_SUCCESS);
		idle();
		act(ACT_CLOSE, OUT_SUCCESS);
		rd(ADDR_CORR_SEL, d); `CHK("pending", 1'b1, d[CORR_PEND_BIT])
		`CHK("pend out", 1'b1, code_image_pending)
		wr(ADDR_RESTART, 32'h1);
		#1 `CHK("restart", 1'b1, unit_restart_cmd)
		rd(ADDR_CORR_SEL, d); `CHK("pend clr", 1'b0, d[CORR_PEND_BIT])
		`CHK("pend out clr", 1'b0, code_image_pending)
	endtask

	task end_sim();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// the whole sequence needs well under a thousand cycles
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			end_sim();
		end
	end

	initial begin
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		t_reset();
		t_corr();
		t_file();
		t_frame();
		t_restart();
		end_sim();
	end
endmodule
